// >>> src/hspp_top.sv
// strap sampling, indicator, power switch, overcurrent and eeprom pin logic of the hub
`timescale 1ns/100ps
module hspp_top #(
  parameter int unsigned SETTLE_CYC = hspp_pkg::SETTLE_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // test select and mode
  input  wire logic                 test_select,
  output logic                      test_mode,
  // gang strap pin, then suspend indicator
  input  wire logic                 gang_pin_i,
  output logic                      gang_pin_o,
  output logic                      gang_pin_oe_n,
  input  wire logic                 hub_suspend,
  // amber and green pins, shared with straps and four-wire eeprom
  input  wire logic [3:0]           amber_pin_i,
  output logic      [3:0]           amber_pin_o,
  output logic      [3:0]           amber_pin_oe_n,
  input  wire logic [3:0]           green_pin_i,
  output logic      [3:0]           green_pin_o,
  output logic      [3:0]           green_pin_oe_n,
  input  wire logic [3:0]           led_amber_on,
  input  wire logic [3:0]           led_green_on,
  // four-wire eeprom side of the configuration reader
  input  wire logic                 spi_select,
  input  wire hspp_pkg::hspp_spi_t  spi_out,
  output logic                      spi_miso,
  output logic                      spi_ready,
  // two-wire eeprom pins, open drain
  input  wire logic                 i2c_scl_drive_low,
  input  wire logic                 i2c_sda_drive_low,
  input  wire logic                 i2c_scl_i,
  output logic                      i2c_scl_o,
  output logic                      i2c_scl_oe_n,
  input  wire logic                 i2c_sda_i,
  output logic                      i2c_sda_o,
  output logic                      i2c_sda_oe_n,
  output logic                      i2c_scl_in,
  output logic                      i2c_sda_in,
  // power switches and overcurrent
  input  wire logic [3:0]           port_power_on,
  input  wire logic [3:0]           port_power_float,
  output logic      [3:0]           port_power_enable_n_o,
  output logic      [3:0]           port_power_enable_n_oe_n,
  input  wire logic [3:0]           port_overcurrent_n,
  output logic      [3:0]           port_overcurrent,
  // latched configuration
  output hspp_pkg::hspp_straps_t    straps,
  output logic                      straps_valid,
  output logic                      pins_ready
);

  localparam logic [hspp_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
    hspp_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1);

  hspp_pkg::hspp_phase_t                phase_q, phase_d;
  logic [hspp_pkg::SETTLE_CNT_W-1:0]    cnt_q, cnt_d;
  hspp_pkg::hspp_straps_t               straps_q, straps_d;
  logic                                 valid_q;
  logic                                 test_q;
  logic [3:0]                           oc_q;
  logic                                 miso_q;
  logic                                 scl_in_q, sda_in_q;

  // level of a pin asserting 'on' given an active-high select
  function automatic logic active_level(input logic high_active, input logic on);
    active_level = high_active ? on : ~on;
  endfunction : active_level

  // phase sequencing: one sample cycle, settle count, then run
  wire sample_now  = (phase_q == hspp_pkg::ST_SAMPLE);
  wire settle_done = (cnt_q == SETTLE_LAST);
  wire run         = (phase_q == hspp_pkg::ST_RUN);

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    case (phase_q)
      hspp_pkg::ST_SAMPLE: begin
        phase_d = hspp_pkg::ST_SETTLE;
        cnt_d   = hspp_pkg::SETTLE_CNT_RST;
      end
      hspp_pkg::ST_SETTLE: begin
        if (settle_done) begin
          phase_d = hspp_pkg::ST_RUN;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      hspp_pkg::ST_RUN: begin
        phase_d = hspp_pkg::ST_RUN;
      end
      default: begin
        phase_d = hspp_pkg::ST_SAMPLE;
        cnt_d   = hspp_pkg::SETTLE_CNT_RST;
      end
    endcase
  end

  // strap capture from the still-released pins in the first cycle
  always_comb begin
    straps_d = straps_q;
    if (sample_now && !valid_q) begin
      straps_d.nonremovable   = green_pin_i;
      straps_d.power_pol_high = amber_pin_i[hspp_pkg::POL_STRAP_PORT];
      straps_d.port_numbering = {amber_pin_i[hspp_pkg::NUM_HI_PORT],
                                 amber_pin_i[hspp_pkg::NUM_LO_PORT]};
      straps_d.gang_mode      = gang_pin_i;
    end
  end

  // phase, counter and latched straps; straps never reload until reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q  <= hspp_pkg::ST_SAMPLE;
      cnt_q    <= hspp_pkg::SETTLE_CNT_RST;
      straps_q <= hspp_pkg::STRAPS_RST;
      valid_q  <= 1'b0;
    end else begin
      phase_q  <= phase_d;
      cnt_q    <= cnt_d;
      straps_q <= straps_d;
      valid_q  <= valid_q | sample_now;
    end
  end

  // registered plain inputs; overcurrent is inverted, and in gang mode any port's flag is set on all
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      test_q   <= 1'b0;
      oc_q     <= 4'h0;
      miso_q   <= 1'b0;
      scl_in_q <= 1'b1;
      sda_in_q <= 1'b1;
    end else begin
      test_q   <= test_select;
      oc_q     <= straps_q.gang_mode ? {4{|(~port_overcurrent_n)}}
                                     : ~port_overcurrent_n;
      miso_q   <= green_pin_i[hspp_pkg::SPI_MISO_PORT];
      scl_in_q <= i2c_scl_i;
      sda_in_q <= i2c_sda_i;
    end
  end

  // four-wire eeprom owns its pins only once they are outputs
  wire spi_on = run && spi_select;

  // indicator pins: strap inputs until run, then led or eeprom drive
  wire [3:0] amber_val, amber_drv, green_val, green_drv;

  genvar p;
  generate
    for (p = 0; p < hspp_pkg::NUM_PORTS; p++) begin : g_port
      localparam bit CS_HERE   = (p == hspp_pkg::SPI_CS_PORT);
      localparam bit MOSI_HERE = (p == hspp_pkg::SPI_MOSI_PORT);
      localparam bit SK_HERE   = (p == hspp_pkg::SPI_CLK_PORT);
      localparam bit MISO_HERE = (p == hspp_pkg::SPI_MISO_PORT);

      // amber: chip select or data-out override the led when selected
      assign amber_drv[p] = run;
      assign amber_val[p] = (spi_on && CS_HERE)   ? spi_out.cs :
                            (spi_on && MOSI_HERE) ? spi_out.mosi :
                            led_amber_on[p];
      // green: clock overrides, data-in pin is released to listen
      assign green_drv[p] = run && !(spi_on && MISO_HERE);
      assign green_val[p] = (spi_on && SK_HERE) ? spi_out.sk :
                            led_green_on[p];

      hspp_out_pad u_amber (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .drive    (amber_drv[p]),
        .value    (amber_val[p]),
        .pin_o    (amber_pin_o[p]),
        .pin_oe_n (amber_pin_oe_n[p])
      );

      hspp_out_pad u_green (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .drive    (green_drv[p]),
        .value    (green_val[p]),
        .pin_o    (green_pin_o[p]),
        .pin_oe_n (green_pin_oe_n[p])
      );

      // power switch: gang mode follows port 1's request and float
      wire power_req   = straps_q.gang_mode ? port_power_on[0] : port_power_on[p];
      wire power_float = straps_q.gang_mode ? port_power_float[0] : port_power_float[p];
      wire power_drv   = valid_q && !power_float;
      wire power_val   = active_level(straps_q.power_pol_high, power_req);

      hspp_out_pad u_power (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .drive    (power_drv),
        .value    (power_val),
        .pin_o    (port_power_enable_n_o[p]),
        .pin_oe_n (port_power_enable_n_oe_n[p])
      );
    end
  endgenerate

  // gang pin: gang mode shows suspend high, individual shows it low
  wire gang_val = active_level(straps_q.gang_mode, hub_suspend);

  hspp_out_pad u_gang (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .drive    (run),
    .value    (gang_val),
    .pin_o    (gang_pin_o),
    .pin_oe_n (gang_pin_oe_n)
  );

  // two-wire pins are open drain: only ever pulled low, never driven high
  hspp_out_pad u_scl (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .drive    (i2c_scl_drive_low),
    .value    (1'b0),
    .pin_o    (i2c_scl_o),
    .pin_oe_n (i2c_scl_oe_n)
  );

  hspp_out_pad u_sda (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .drive    (i2c_sda_drive_low),
    .value    (1'b0),
    .pin_o    (i2c_sda_o),
    .pin_oe_n (i2c_sda_oe_n)
  );

  // outputs
  assign test_mode        = test_q;
  assign port_overcurrent = oc_q;
  assign spi_miso         = miso_q;
  assign spi_ready        = run;
  assign i2c_scl_in       = scl_in_q;
  assign i2c_sda_in       = sda_in_q;
  assign straps           = straps_q;
  assign straps_valid     = valid_q;
  assign pins_ready       = run;

endmodule : hspp_top

// >>> common/hspp_pkg.sv
// constants and carrier types of the hub strap and port pin block
package hspp_pkg;

  localparam int unsigned NUM_PORTS      = 4;
  localparam int unsigned CLK_HZ         = 25_000_000;
  // settle time after reset release before strap pins turn to outputs
  localparam int unsigned SETTLE_MS      = 60;
  localparam int unsigned SETTLE_CYCLES  = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned SETTLE_CNT_W   = 21;

  // port slots whose indicator pins double as four-wire eeprom pins
  localparam int unsigned SPI_CS_PORT    = 0;  // amber pin of port 1
  localparam int unsigned SPI_CLK_PORT   = 0;  // green pin of port 1
  localparam int unsigned SPI_MOSI_PORT  = 1;  // amber pin of port 2
  localparam int unsigned SPI_MISO_PORT  = 1;  // green pin of port 2

  // port slots whose amber pins carry the global straps
  localparam int unsigned POL_STRAP_PORT = 1;  // amber pin of port 2
  localparam int unsigned NUM_HI_PORT    = 2;  // amber pin of port 3
  localparam int unsigned NUM_LO_PORT    = 3;  // amber pin of port 4

  // values after reset
  localparam logic        PIN_O_RST      = 1'b0;
  localparam logic        PIN_OE_N_RST   = 1'b1;  // released, pin is an input
  localparam logic [SETTLE_CNT_W-1:0] SETTLE_CNT_RST = 21'h000000;

  // straps caught once at reset release
  typedef struct packed {
    logic [3:0] nonremovable;    // per port, high means fixed port
    logic       power_pol_high;  // power enable is active high
    logic [1:0] port_numbering;  // {hi strap, lo strap}
    logic       gang_mode;       // high gang, low individual
  } hspp_straps_t;

  localparam hspp_straps_t STRAPS_RST = '0;

  // four-wire eeprom outputs from the configuration reader
  typedef struct packed {
    logic cs;
    logic sk;
    logic mosi;
  } hspp_spi_t;

  // pin sequencing after reset
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b11
  } hspp_phase_t;

endpackage : hspp_pkg

// >>> src/hspp_out_pad.sv
// registered output stage of one pad, enable low while driving
`timescale 1ns/100ps
module hspp_out_pad (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic drive,
  input  wire logic value,
  output logic      pin_o,
  output logic      pin_oe_n
);

  // pad stays released through reset so straps can be read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_o    <= hspp_pkg::PIN_O_RST;
      pin_oe_n <= hspp_pkg::PIN_OE_N_RST;
    end else begin
      pin_o    <= drive ? value : hspp_pkg::PIN_O_RST;
      pin_oe_n <= ~drive;
    end
  end

endmodule : hspp_out_pad

// >>> tb/hspp_sva.sv
// assertions on the pins of the hub strap and port pin block
`timescale 1ns/100ps
module hspp_sva #(
  parameter int unsigned SETTLE_CYC = 8
) (
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  input wire logic                   test_select,
  input wire logic                   test_mode,
  input wire logic                   gang_pin_o,
  input wire logic                   hub_suspend,
  input wire logic [3:0]             amber_pin_i,
  input wire logic [3:0]             amber_pin_o,
  input wire logic [3:0]             amber_pin_oe_n,
  input wire logic [3:0]             green_pin_i,
  input wire logic [3:0]             green_pin_o,
  input wire logic [3:0]             green_pin_oe_n,
  input wire logic [3:0]             led_amber_on,
  input wire logic [3:0]             led_green_on,
  input wire logic                   gang_pin_i,
  input wire logic                   spi_select,
  input wire hspp_pkg::hspp_spi_t    spi_out,
  input wire logic                   i2c_sda_drive_low,
  input wire logic                   i2c_sda_o,
  input wire logic                   i2c_sda_oe_n,
  input wire logic [3:0]             port_power_on,
  input wire logic [3:0]             port_power_float,
  input wire logic [3:0]             port_power_enable_n_o,
  input wire logic [3:0]             port_power_enable_n_oe_n,
  input wire logic [3:0]             port_overcurrent_n,
  input wire logic [3:0]             port_overcurrent,
  input wire hspp_pkg::hspp_straps_t straps,
  input wire logic                   straps_valid,
  input wire logic                   pins_ready
);
  logic [20:0] wait_q;
  // settle cycles seen since strap capture, wide enough for the real count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) wait_q <= 21'h000000;
    else if (straps_valid && !pins_ready) wait_q <= wait_q + 21'h000001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // checks on strap capture, pin turnaround and the pin functions
  test_follow_a: assert property (1'b1 |=> test_mode == $past(test_select))
    else $error("test mode differs from select");
  strap_map_a: assert property ($rose(straps_valid) |-> straps == {$past(green_pin_i),
    $past(amber_pin_i[1]), $past(amber_pin_i[2]), $past(amber_pin_i[3]), $past(gang_pin_i)})
    else $error("straps not taken from pins");
  strap_hold_a: assert property ($past(straps_valid) |-> $stable(straps))
    else $error("straps changed after capture");
  pins_released_a: assert property (!pins_ready |=> &amber_pin_oe_n && &green_pin_oe_n)
    else $error("strap pin driven before settle");
  settle_time_a: assert property ($rose(pins_ready) |-> wait_q == SETTLE_CYC)
    else $error("settle time wrong");
  led_drive_a: assert property (pins_ready |=> !amber_pin_oe_n[3] &&
    {amber_pin_o[3:2], green_pin_o[3:2]} == {$past(led_amber_on[3:2]), $past(led_green_on[3:2])})
    else $error("indicator pins wrong");
  power_drive_a: assert property (straps_valid && !straps.gang_mode |=>
    port_power_enable_n_oe_n == $past(port_power_float) && port_power_enable_n_o ==
    ((straps.power_pol_high ? $past(port_power_on) : ~$past(port_power_on)) &
     ~$past(port_power_float)))
    else $error("power enable pins wrong");
  over_current_a: assert property (straps_valid && !straps.gang_mode |=>
    port_overcurrent == ~$past(port_overcurrent_n)) else $error("overcurrent wrong");
  eeprom_pins_a: assert property (pins_ready && spi_select |=>
    {amber_pin_o[1:0], green_pin_o[0], green_pin_oe_n[1]} ==
    {$past(spi_out.mosi), $past(spi_out.cs), $past(spi_out.sk), 1'b1}) else $error("eeprom pins");
  sda_low_a: assert property (i2c_sda_drive_low |=> !i2c_sda_oe_n && !i2c_sda_o)
    else $error("data line not pulled low");
  gang_pin_a: assert property (pins_ready |=>
    gang_pin_o == (straps.gang_mode ~^ $past(hub_suspend))) else $error("gang pin wrong");
  // main scenarios reached
  cover property ($rose(pins_ready));
  cover property (pins_ready && spi_select);
  cover property (straps_valid && straps.gang_mode);
endmodule : hspp_sva

bind hspp_top hspp_sva #(.SETTLE_CYC(SETTLE_CYC)) i_hspp_sva (.*);

// >>> tb/hspp_board.sv
// pads, strap resistors and eeprom data line around the indicator pins
`timescale 1ns/100ps
module hspp_board (
  input  wire logic [3:0] amber_pin_o,
  input  wire logic [3:0] amber_pin_oe_n,
  input  wire logic [3:0] green_pin_o,
  input  wire logic [3:0] green_pin_oe_n,
  input  wire logic [3:0] amber_lvl,  // strap level while released
  input  wire logic [3:0] green_lvl,  // strap level, eeprom data on port 2
  output logic      [3:0] amber_pin_i,
  output logic      [3:0] green_pin_i
);
  // strap is weak and yields once the device drives, so leds stay usable
  assign amber_pin_i = (amber_pin_oe_n & amber_lvl) | (~amber_pin_oe_n & amber_pin_o);
  assign green_pin_i = (green_pin_oe_n & green_lvl) | (~green_pin_oe_n & green_pin_o);
endmodule : hspp_board

// >>> tb/hspp_top_tb.sv
// self-checking bench of the hub strap and port pin block
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module hspp_top_tb;
  localparam int unsigned ST = 8;  // short settle count keeps the run brief
  logic ref_clk, nrst, test_select, gang_pin_i, hub_suspend, spi_select, spi_miso, spi_ready;
  logic test_mode, gang_pin_o, gang_pin_oe_n, i2c_scl_drive_low, i2c_sda_drive_low;
  logic i2c_scl_i, i2c_sda_i, i2c_scl_o, i2c_scl_oe_n, i2c_sda_o, i2c_sda_oe_n;
  logic i2c_scl_in, i2c_sda_in, straps_valid, pins_ready;
  logic [3:0] amber_pin_i, amber_pin_o, amber_pin_oe_n, green_pin_i, green_pin_o, green_pin_oe_n;
  logic [3:0] led_amber_on, led_green_on, port_power_on, port_power_float, port_power_enable_n_o;
  logic [3:0] port_power_enable_n_oe_n, port_overcurrent_n, port_overcurrent, amber_lvl, green_lvl;
  hspp_pkg::hspp_spi_t    spi_out;
  hspp_pkg::hspp_straps_t straps;
  int failures, n_compared, k;

  hspp_top #(.SETTLE_CYC(ST)) i_hspp_top (.*);
  hspp_board i_hspp_board (.*);
  // two-wire lines have pull-ups, so a released line reads high
  assign i2c_scl_i = i2c_scl_oe_n;
  assign i2c_sda_i = i2c_sda_oe_n;

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task end_of_test;
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // inputs always change 1 ns after the rising edge
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // reset with given strap levels, then time the settle phase
  task boot(input logic [3:0] a, input logic [3:0] g, input logic gm);
    nrst = 1'b0;
    amber_lvl = a;
    green_lvl = g;
    gang_pin_i = gm;
    step(16);
    nrst = 1'b1;
    step(1);
    `CHK("straps", {g, a[1], a[2], a[3], gm}, straps)
    amber_lvl = ~a;
    green_lvl = ~g;
    gang_pin_i = ~gm;
    `CHK("released", 8'hff, {amber_pin_oe_n, green_pin_oe_n})
    k = 0;
    while (pins_ready !== 1'b1 && k < 20) begin
      step(1);
      k++;
    end
    `CHK("settle", ST, k)
    `CHK("ready", 1'b1, spi_ready)
    if (k == 20) end_of_test();
    step(1);
    `CHK("kept", {g, a[1], a[2], a[3], gm}, straps)
  endtask : boot

  // gang mode with active-high power enable
  task t_strap;
    boot(4'h6, 4'h9, 1'b1);
    port_power_on = 4'h1;
    port_overcurrent_n = 4'hb;
    hub_suspend = 1'b1;
    step(1);
    `CHK("gang power", 4'hf, port_power_enable_n_o)
    `CHK("gang overcurrent", 4'hf, port_overcurrent)
    `CHK("suspend pin", 2'h2, {gang_pin_o, gang_pin_oe_n})
  endtask : t_strap

  // individual mode, leds, eeprom pins, test select
  task t_run;
    boot(4'h0, 4'h0, 1'b0);
    `CHK("pins driven", 8'h00, {amber_pin_oe_n, green_pin_oe_n})
    led_amber_on = 4'ha;
    led_green_on = 4'h5;
    port_power_on = 4'h6;
    port_power_float = 4'h8;
    port_overcurrent_n = 4'hd;
    test_select = 1'b1;
    i2c_sda_drive_low = 1'b1;
    i2c_scl_drive_low = 1'b1;
    step(1);
    `CHK("leds", 8'ha5, {amber_pin_o, green_pin_o})
    // a floated switch pin is parked low behind its released enable
    `CHK("power", 8'h18, {port_power_enable_n_o, port_power_enable_n_oe_n})
    `CHK("overcurrent", 4'h2, port_overcurrent)
    `CHK("test", 1'b1, test_mode)
    `CHK("two-wire", 4'h0, {i2c_scl_oe_n, i2c_sda_oe_n, i2c_scl_o, i2c_sda_o})
    spi_select = 1'b1;
    spi_out = 3'h5;
    green_lvl = 4'h2;
    step(1);
    `CHK("two-wire in", 2'h0, {i2c_scl_in, i2c_sda_in})
    `CHK("eeprom pins", 4'hd, {amber_pin_o[1:0], green_pin_o[0], green_pin_oe_n[1]})
    `CHK("led kept", 2'h2, amber_pin_o[3:2])
    test_select = 1'b0;
    step(1);
    `CHK("eeprom data", 1'b1, spi_miso)
    `CHK("test off", 1'b0, test_mode)
  endtask : t_run

  // main sequence
  initial begin
    {test_select, gang_pin_i, hub_suspend, spi_select, i2c_scl_drive_low} = 5'h00;
    i2c_sda_drive_low = 1'b0;
    {led_amber_on, led_green_on, port_power_on, port_power_float} = 16'h0000;
    {amber_lvl, green_lvl} = 8'h00;
    port_overcurrent_n = 4'hf;
    spi_out = 3'h0;
    nrst = 1'b0;
    failures = 0;
    n_compared = 0;
    t_strap();
    t_run();
    end_of_test();
  end
endmodule : hspp_top_tb
